/* adccc_map.svh */
// Constants of the converter control block
// What this block does
// - Select four single-ended, one pair, three-vs-fourth
// - Input selection is three-bit configuration field
// - Single-ended: negative input switched to ground
// - Six gains with matching full-scale ranges
// - Gain selection is three-bit configuration field
// - Gainless variant always uses 2.048V range
// - Result is 16-bit twos-complement value
// - Results saturate at 7FFFh and 8000h
// - Zero codes 0, steps code 0001h/FFFFh
// - Continuous: store result, restart at once
// - Single-shot idles until start bit written
// - Start bit reads 0 while converting
// - Done: start bit returns 1, power down
// - Start write during conversion is ignored
// - Power-up reset restores configuration defaults
// - General call reset equals power-on reset
// - Continuous repeats at rate; read latest result
`ifndef ADCCC_MAP_SVH
`define ADCCC_MAP_SVH

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ADCCC_MUX_RST    3'h0
`define ADCCC_GAIN_RST   3'h2
`define ADCCC_RATE_RST   3'h4
`define ADCCC_RESULT_RST 16'h0000

// ----------------------------------------
// Codes
// ----------------------------------------
`define ADCCC_POS_CLIP   16'h7fff
`define ADCCC_NEG_CLIP   16'h8000
`define ADCCC_GAIN_FIXED 3'h2
`define ADCCC_GAIN_MAX   3'h5

// ----------------------------------------
// Timing
// ----------------------------------------
`define ADCCC_CLK_HZ     25000000

`endif

/* adccc_pkg.sv */
// Types of the converter control block
package adccc_pkg;

    // Analog switch setting presented to the front end
    typedef struct packed {
        logic [1:0] pos_sel;   // Positive input index 0..3
        logic [1:0] neg_sel;   // Negative input index 0..3
        logic       neg_gnd;   // Negative input tied to ground
    } adccc_route_t;

    // Configuration fields
    typedef struct packed {
        logic [2:0] mux;       // Input selection
        logic [2:0] gain;      // Gain selection
        logic [2:0] rate;      // Data rate selection
        logic       single;    // 1: single-shot, 0: continuous
    } adccc_cfg_t;

    typedef enum logic [2:0] {
        ADCCC_IDLE = 3'b001,
        ADCCC_CONV = 3'b010,
        ADCCC_DONE = 3'b100
    } adccc_state_t;

endpackage

/* adccc_ctrl.sv */
// Converter conversion control, routing and result formatting
`timescale 1ns/1ps
`include "adccc_map.svh"

module adccc_ctrl #(
    parameter int HAS_GAIN   = 1,        // 0 for the gainless variant
    parameter int RAW_W      = 24,       // Width of raw filter output
    parameter int BASE_TICKS = 3125000   // One less than the cycles per conversion at slowest rate
) (
    input  wire logic                    clk,          // 25 MHz clock
    input  wire logic                    rst_n,        // Power-on reset, active low
    input  wire logic                    gencall_rst,  // General call reset pulse
    input  wire logic                    cfg_we,       // Configuration write strobe
    input  wire adccc_pkg::adccc_cfg_t   cfg_wdata,    // Configuration write data
    input  wire logic                    start_wr,     // Start bit written as 1
    input  wire logic signed [RAW_W-1:0] raw_data,     // Raw filter result
    output adccc_pkg::adccc_cfg_t        cfg,          // Current configuration
    output logic                         start_status_bit, // 1 idle/done, 0 converting
    output logic [15:0]                  result,       // Latest result, twos complement
    output logic                         result_valid, // One-cycle pulse on new result
    output adccc_pkg::adccc_route_t      route,        // Switch setting for conversion
    output logic [2:0]                   gain_stage,   // Gain applied this conversion
    output logic                         powered_down, // Front end shut down
    output logic                         conv_active   // Modulator running
);

    // ----------------------------------------
    // Types and state
    // ----------------------------------------
    adccc_pkg::adccc_state_t state;
    adccc_pkg::adccc_state_t next_state;
    logic [31:0] tick;
    logic [31:0] conv_len;
    logic        soft_rst;
    logic        conv_end;
    logic        begin_conv;
    logic [15:0] next_result;

    assign soft_rst = gencall_rst;

    // ----------------------------------------
    // Configuration register
    // ----------------------------------------
    // defaults on either reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= '{mux: `ADCCC_MUX_RST, gain: `ADCCC_GAIN_RST, rate: `ADCCC_RATE_RST, single: 1'b1};
        end else if (soft_rst) begin
            cfg <= '{mux: `ADCCC_MUX_RST, gain: `ADCCC_GAIN_RST, rate: `ADCCC_RATE_RST, single: 1'b1};
        end else if (cfg_we) begin
            cfg <= cfg_wdata;
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    // Conversion length halves with each rate step
    assign conv_len = (BASE_TICKS >> cfg.rate) + 32'h1;
    assign conv_end = (state == adccc_pkg::ADCCC_CONV) && (tick == 32'h0);
    assign begin_conv = (state == adccc_pkg::ADCCC_IDLE) &&
                        (!cfg.single || start_wr);

    always_comb begin
        next_state = state;
        unique case (state)
            adccc_pkg::ADCCC_IDLE: begin
                if (begin_conv) begin
                    next_state = adccc_pkg::ADCCC_CONV;
                end
            end
            adccc_pkg::ADCCC_CONV: begin
                if (conv_end) begin
                    next_state = cfg.single ? adccc_pkg::ADCCC_DONE : adccc_pkg::ADCCC_CONV;
                end
            end
            adccc_pkg::ADCCC_DONE: begin
                next_state = adccc_pkg::ADCCC_IDLE;
            end
            default: begin
                next_state = adccc_pkg::ADCCC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= adccc_pkg::ADCCC_IDLE;
        end else if (soft_rst) begin
            state <= adccc_pkg::ADCCC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick <= 32'h0;
        end else if (soft_rst) begin
            tick <= 32'h0;
        end else if (begin_conv || (conv_end && !cfg.single)) begin
            tick <= conv_len - 32'h1;
        end else if (state == adccc_pkg::ADCCC_CONV) begin
            tick <= tick - 32'h1;
        end
    end

    // ----------------------------------------
    // Routing latched per conversion
    // ----------------------------------------
    // fields sampled only at conversion start
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            route      <= '0;
            gain_stage <= `ADCCC_GAIN_RST;
        end else if (soft_rst) begin
            // General call returns the switches to their power-on setting
            route      <= '0;
            gain_stage <= `ADCCC_GAIN_RST;
        end else if (begin_conv || (conv_end && !cfg.single)) begin
            unique case (cfg.mux)
                3'h0: route <= '{pos_sel: 2'h0, neg_sel: 2'h1, neg_gnd: 1'b0};
                3'h1: route <= '{pos_sel: 2'h0, neg_sel: 2'h3, neg_gnd: 1'b0};
                3'h2: route <= '{pos_sel: 2'h1, neg_sel: 2'h3, neg_gnd: 1'b0};
                3'h3: route <= '{pos_sel: 2'h2, neg_sel: 2'h3, neg_gnd: 1'b0};
                3'h4: route <= '{pos_sel: 2'h0, neg_sel: 2'h0, neg_gnd: 1'b1};
                3'h5: route <= '{pos_sel: 2'h1, neg_sel: 2'h0, neg_gnd: 1'b1};
                3'h6: route <= '{pos_sel: 2'h2, neg_sel: 2'h0, neg_gnd: 1'b1};
                3'h7: route <= '{pos_sel: 2'h3, neg_sel: 2'h0, neg_gnd: 1'b1};
            endcase
            // gain choice, fixed without gain stage
            if (HAS_GAIN == 0) begin
                gain_stage <= `ADCCC_GAIN_FIXED;
            end else if (cfg.gain > `ADCCC_GAIN_MAX) begin
                gain_stage <= `ADCCC_GAIN_MAX;
            end else begin
                gain_stage <= cfg.gain;
            end
        end
    end

    // ----------------------------------------
    // Result formatting
    // ----------------------------------------
    // clip to 16-bit twos complement
    always_comb begin
        if (raw_data > $signed({{(RAW_W-16){1'b0}}, `ADCCC_POS_CLIP})) begin
            next_result = `ADCCC_POS_CLIP;
        end else if (raw_data < $signed({{(RAW_W-16){1'b1}}, `ADCCC_NEG_CLIP})) begin
            next_result = `ADCCC_NEG_CLIP;
        end else begin
            next_result = raw_data[15:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result       <= `ADCCC_RESULT_RST;
            result_valid <= 1'b0;
        end else if (soft_rst) begin
            result       <= `ADCCC_RESULT_RST;
            result_valid <= 1'b0;
        end else begin
            result_valid <= conv_end;
            if (conv_end) begin
                result <= next_result;
            end
        end
    end

    // ----------------------------------------
    // Status outputs
    // ----------------------------------------
    // start bit low only while converting
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            start_status_bit <= 1'b1;
            powered_down     <= 1'b1;
            conv_active      <= 1'b0;
        end else if (soft_rst) begin
            start_status_bit <= 1'b1;
            powered_down     <= 1'b1;
            conv_active      <= 1'b0;
        end else begin
            start_status_bit <= (next_state != adccc_pkg::ADCCC_CONV);
            powered_down     <= (next_state != adccc_pkg::ADCCC_CONV) && cfg.single;
            conv_active      <= (next_state == adccc_pkg::ADCCC_CONV);
        end
    end

endmodule

/* adccc_ctrl_checker.sv */
// Assertion checker for the converter control block
`timescale 1ns/1ps
`include "adccc_map.svh"
module adccc_ctrl_checker #(
    parameter int RAW_W = 24 // Raw width
) (
    input wire logic                    clk,              // Clock
    input wire logic                    rst_n,            // Reset
    input wire logic                    gencall_rst,      // General call
    input wire logic                    cfg_we,           // Config write
    input wire adccc_pkg::adccc_cfg_t   cfg_wdata,        // Write data
    input wire logic                    start_wr,         // Start
    input wire logic signed [RAW_W-1:0] raw_data,         // Raw value
    input wire adccc_pkg::adccc_cfg_t   cfg,              // Config
    input wire logic                    start_status_bit, // Status
    input wire logic [15:0]             result,           // Result
    input wire logic                    result_valid,     // New result
    input wire adccc_pkg::adccc_route_t route,            // Routing
    input wire logic [2:0]              gain_stage,       // Gain
    input wire logic                    powered_down,     // Off
    input wire logic                    conv_active       // Running
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    function automatic logic [15:0] clp(input logic signed [RAW_W-1:0] v);
        return v > 32767 ? 16'h7fff : v < -32768 ? 16'h8000 : v[15:0];
    endfunction
    start_taken_a: assert property (start_wr && start_status_bit && !conv_active && !result_valid
        && !$past(result_valid) && cfg.single && !gencall_rst |=> !start_status_bit) else $error("start lost");
    busy_flag_a: assert property (start_status_bit != conv_active) else $error("status wrong");
    clip_code_a: assert property (result_valid |-> result == clp($past(raw_data))) else $error("bad code");
    valid_pulse_a: assert property (result_valid |=> !result_valid) else $error("long pulse");
    result_hold_a: assert property (!result_valid && !$past(gencall_rst) |-> $stable(result))
        else $error("result moved");
    gencall_reset_a: assert property (gencall_rst |=> cfg == {`ADCCC_MUX_RST, `ADCCC_GAIN_RST,
        `ADCCC_RATE_RST, 1'b1} && start_status_bit && result == 16'h0000) else $error("no reset");
    cfg_write_a: assert property (cfg_we && !gencall_rst |=> cfg == $past(cfg_wdata)) else $error("no write");
    latch_route_a: assert property ($rose(conv_active) |-> route.neg_gnd == $past(cfg.mux[2])
        && gain_stage == ($past(cfg.gain) > 3'h5 ? 3'h5 : $past(cfg.gain))) else $error("bad latch");
    done_down_a: assert property (result_valid && cfg.single |-> powered_down) else $error("not down");
endmodule

bind adccc_ctrl adccc_ctrl_checker #(.RAW_W(RAW_W)) adccc_ctrl_checker_inst (.clk(clk), .rst_n(rst_n),
    .gencall_rst(gencall_rst), .cfg_we(cfg_we), .cfg_wdata(cfg_wdata), .start_wr(start_wr),
    .raw_data(raw_data), .cfg(cfg), .start_status_bit(start_status_bit), .result(result),
    .result_valid(result_valid), .route(route), .gain_stage(gain_stage), .powered_down(powered_down),
    .conv_active(conv_active));

/* adccc_src.sv */
// Raw filter source standing at the far side of the block
`timescale 1ns/1ps
module adccc_src #(
    parameter int RAW_W = 24 // Raw width
) (
    input  wire logic signed [RAW_W-1:0] value,       // Value for the next result
    input  wire logic                    conv_active, // Modulator running
    output logic signed [RAW_W-1:0]      raw_data     // Raw output
);
    // Filter output is meaningless outside a conversion
    assign raw_data = conv_active ? value : ~value;
endmodule

/* test_adccc_ctrl.sv */
// Testbench of the converter control block
`timescale 1ns/1ps
module test_adccc_ctrl;
    logic                    clk = 0, rst_n = 0, gencall_rst = 0, cfg_we = 0, start_wr = 0;
    adccc_pkg::adccc_cfg_t   cfg_wdata = '0, cfg;
    logic signed [23:0]      value = '0, raw_data;
    logic                    start_status_bit, result_valid, powered_down, conv_active;
    logic [15:0]             result;
    adccc_pkg::adccc_route_t route;
    logic [2:0]              gain_stage;
    int                      failures = 0, num_checks = 0, cyc = 0, n;
    logic [23:0] raws[7] = '{24'h010000, 24'h007fff, 24'h000001, 24'h0, 24'hffffff, 24'hff8000, 24'hff7000};
    logic [15:0] exps[7] = '{16'h7fff, 16'h7fff, 16'h0001, 16'h0, 16'hffff, 16'h8000, 16'h8000};
    logic [1:0]  pe[8] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h0, 2'h1, 2'h2, 2'h3};
    always #20 clk = ~clk;
    adccc_ctrl #(.BASE_TICKS(16)) adccc_ctrl_inst (.clk(clk), .rst_n(rst_n), .gencall_rst(gencall_rst),
        .cfg_we(cfg_we), .cfg_wdata(cfg_wdata), .start_wr(start_wr), .raw_data(raw_data), .cfg(cfg),
        .start_status_bit(start_status_bit), .result(result), .result_valid(result_valid), .route(route),
        .gain_stage(gain_stage), .powered_down(powered_down), .conv_active(conv_active));
    adccc_src adccc_src_inst (.value(value), .conv_active(conv_active), .raw_data(raw_data));
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic set_cfg(input logic [9:0] c);
        @(negedge clk) cfg_wdata = c;
        cfg_we = 1;
        @(negedge clk) cfg_we = 0;
    endtask
    task automatic go;
        @(negedge clk) start_wr = 1;
        @(negedge clk) start_wr = 0;
    endtask
    // Counts busy cycles into n, bounded
    task automatic fin;
        n = 0;
        while (start_status_bit === 1'b0 && n < 100) begin
            n++;
            @(negedge clk);
        end
        chk(result_valid, 24'h1);
        chk(powered_down, 24'h1);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            finish_test;
        end
    end
    initial begin
        repeat (2) @(negedge clk);
        rst_n = 1;
        chk(cfg, 24'h029);
        chk({start_status_bit, powered_down, result}, 24'h30000);
        for (int i = 0; i < 7; i++) begin
            set_cfg({3'h0, 3'h2, 3'(i % 5), 1'b1});
            value = raws[i];
            go;
            chk(start_status_bit, 24'h0);
            fin;
            chk(24'(n), 24'((16 >> (i % 5)) + 1));
            chk(result, exps[i]);
        end
        for (int m = 0; m < 8; m++) begin
            set_cfg({3'(m), 3'(m), 3'h0, 1'b1});
            go;
            chk({route.pos_sel, route.neg_gnd, gain_stage}, {pe[m], m >= 4, m > 5 ? 3'h5 : 3'(m)});
            set_cfg({3'(~m), 3'h0, 3'h0, 1'b1});
            go;
            fin;
            chk({route.pos_sel, route.neg_gnd}, {pe[m], m >= 4});
            repeat (3) @(negedge clk);
            chk(start_status_bit, 24'h1);
        end
        set_cfg(10'h028);
        value = 24'h001234;
        n = 0;
        repeat (20) @(negedge clk) n += result_valid;
        chk(n > 4, 24'h1);
        chk({powered_down, result}, 24'h01234);
        @(negedge clk) gencall_rst = 1;
        @(negedge clk) gencall_rst = 0;
        chk(cfg, 24'h029);
        chk(result, 24'h0);
        set_cfg(10'h3ff);
        rst_n = 0;
        @(negedge clk) rst_n = 1;
        chk(cfg, 24'h029);
        finish_test;
    end
endmodule
